// ===== phymc_pkg.sv
// shared constants and types for the phy management register slice
package phymc_pkg;

	// management register numbers
	localparam logic [4:0]  PHYMC_REG_LPNP    = 5'h08;
	localparam logic [4:0]  PHYMC_REG_MIICTL  = 5'h14;
	localparam logic [4:0]  PHYMC_REG_SERCNT  = 5'h15;
	localparam logic [4:0]  PHYMC_REG_INTCS   = 5'h1B;

	// preamble control field layout and reset values
	localparam int          PHYMC_BIT_PRE100  = 7;
	localparam int          PHYMC_BIT_PRE10   = 6;
	localparam logic [7:0]  PHYMC_MIICTL_HI   = 8'h00;
	localparam logic [5:0]  PHYMC_MIICTL_LO   = 6'h01;
	localparam logic [2:0]  PHYMC_STRAP_P100  = 3'h4;
	localparam logic [1:0]  PHYMC_STRAP_WAIT  = 2'h3;

	// interrupt enables sit above the status byte
	localparam int          PHYMC_ENA_MSB     = 15;
	localparam int          PHYMC_ENA_LSB     = 8;
	localparam int          PHYMC_NUM_SRC     = 8;
	localparam logic [15:0] PHYMC_CNT_MAX     = 16'hFFFF;
	localparam logic [15:0] PHYMC_CNT_ONE     = 16'h0001;

	// management frame fields
	localparam logic [5:0]  PHYMC_MD_PRE_ONES = 6'h20;
	localparam logic [5:0]  PHYMC_MD_HDR_LAST = 6'h0C;
	localparam logic [5:0]  PHYMC_MD_DAT_LAST = 6'h0F;
	localparam logic [1:0]  PHYMC_MD_OP_RD    = 2'h2;
	localparam logic [1:0]  PHYMC_MD_OP_WR    = 2'h1;

	// receive nibble stream
	localparam logic [3:0]  PHYMC_NIB_SFD     = 4'hD;
	localparam logic [1:0]  PHYMC_DROP100     = 2'h2;

	typedef enum logic [4:0] {
		PHYMC_MD_PRE = 5'h01,
		PHYMC_MD_HDR = 5'h02,
		PHYMC_MD_TA  = 5'h04,
		PHYMC_MD_RD  = 5'h08,
		PHYMC_MD_WR  = 5'h10
	} phymc_md_state_e;

endpackage

// ===== phymc_mdio.sv
// serial management frame engine: sync, decode, shift out read data
`timescale 1ns/100ps
module phymc_mdio
	import phymc_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        mdc_i,
	input  wire logic        mdio_i,
	input  wire logic [4:0]  phy_addr_i,
	input  wire logic [15:0] rd_data_i,
	output logic             mdio_o,
	output logic             mdio_oe_o,
	output logic             rd_stb_o,
	output logic             wr_stb_o,
	output logic [4:0]       reg_addr_o,
	output logic [15:0]      wr_data_o
);

	typedef struct packed {
		logic            mdc_s1;
		logic            mdc_s2;
		logic            mdc_s3;
		logic            md_s1;
		logic            md_s2;
		phymc_md_state_e st;
		logic [5:0]      cnt;
		logic [15:0]     sh;
		logic            rd;
		logic [4:0]      addr;
		logic            out;
		logic            oe;
		logic            rd_stb;
		logic            wr_stb;
		logic [15:0]     wdat;
	} phymc_md_s;

	localparam phymc_md_s MD_RST = '{st: PHYMC_MD_PRE, default: '0};

	phymc_md_s   r_r;
	phymc_md_s   r_nxt;
	logic [12:0] hdr;
	logic        rise;

	assign hdr  = {r_r.sh[11:0], r_r.md_s2};
	assign rise = r_r.mdc_s2 && !r_r.mdc_s3;

	always_comb
	begin
		r_nxt        = r_r;
		r_nxt.mdc_s1 = mdc_i;
		r_nxt.mdc_s2 = r_r.mdc_s1;
		r_nxt.mdc_s3 = r_r.mdc_s2;
		r_nxt.md_s1  = mdio_i;
		r_nxt.md_s2  = r_r.md_s1;
		r_nxt.rd_stb = 1'b0;
		r_nxt.wr_stb = 1'b0;
		// capture in the clear cycle, so a status set just before it is not lost
		if (r_r.rd_stb)
			r_nxt.sh = rd_data_i;
		if (rise)
		begin
			case (r_r.st)
			PHYMC_MD_PRE:
			begin
				if (r_r.md_s2)
				begin
					if (r_r.cnt != PHYMC_MD_PRE_ONES)
						r_nxt.cnt = r_r.cnt + 6'h01;
				end
				else
				begin
					if (r_r.cnt == PHYMC_MD_PRE_ONES)
						r_nxt.st = PHYMC_MD_HDR;
					r_nxt.cnt = '0;
				end
			end
			PHYMC_MD_HDR:
			begin
				r_nxt.sh  = {r_r.sh[14:0], r_r.md_s2};
				r_nxt.cnt = r_r.cnt + 6'h01;
				if (r_r.cnt == PHYMC_MD_HDR_LAST)
				begin
					r_nxt.cnt  = '0;
					r_nxt.addr = hdr[4:0];
					r_nxt.rd   = (hdr[11:10] == PHYMC_MD_OP_RD);
					if (hdr[12] && hdr[9:5] == phy_addr_i
						&& (hdr[11:10] == PHYMC_MD_OP_RD || hdr[11:10] == PHYMC_MD_OP_WR))
						r_nxt.st = PHYMC_MD_TA;
					else
						r_nxt.st = PHYMC_MD_PRE;
				end
			end
			PHYMC_MD_TA:
			begin
				r_nxt.cnt = r_r.cnt + 6'h01;
				if (r_r.cnt == '0)
				begin
					// read data is loaded in the strobe cycle that follows
					r_nxt.oe     = r_r.rd;
					r_nxt.out    = 1'b0;
					r_nxt.rd_stb = r_r.rd;
				end
				else
				begin
					r_nxt.cnt = '0;
					r_nxt.st  = r_r.rd ? PHYMC_MD_RD : PHYMC_MD_WR;
					if (r_r.rd)
					begin
						r_nxt.out = r_r.sh[15];
						r_nxt.sh  = {r_r.sh[14:0], 1'b0};
					end
				end
			end
			PHYMC_MD_RD:
			begin
				r_nxt.cnt = r_r.cnt + 6'h01;
				r_nxt.out = r_r.sh[15];
				r_nxt.sh  = {r_r.sh[14:0], 1'b0};
				if (r_r.cnt == PHYMC_MD_DAT_LAST)
				begin
					r_nxt.oe  = 1'b0;
					r_nxt.out = 1'b0;
					r_nxt.cnt = '0;
					r_nxt.st  = PHYMC_MD_PRE;
				end
			end
			PHYMC_MD_WR:
			begin
				r_nxt.sh  = {r_r.sh[14:0], r_r.md_s2};
				r_nxt.cnt = r_r.cnt + 6'h01;
				if (r_r.cnt == PHYMC_MD_DAT_LAST)
				begin
					r_nxt.wr_stb = 1'b1;
					r_nxt.wdat   = {r_r.sh[14:0], r_r.md_s2};
					r_nxt.cnt    = '0;
					r_nxt.st     = PHYMC_MD_PRE;
				end
			end
			default:
			begin
				r_nxt = MD_RST;
			end
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			r_r <= MD_RST;
		else
			r_r <= r_nxt;
	end

	assign mdio_o     = r_r.out;
	assign mdio_oe_o  = r_r.oe;
	assign rd_stb_o   = r_r.rd_stb;
	assign wr_stb_o   = r_r.wr_stb;
	assign reg_addr_o = r_r.addr;
	assign wr_data_o  = r_r.wdat;

endmodule // phymc_mdio

// ===== phymc_preamble.sv
// receive nibble stream preamble drop or restore
`timescale 1ns/100ps
module phymc_preamble
	import phymc_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       speed100_i,
	input  wire logic       restore100_i,
	input  wire logic       restore10_i,
	input  wire logic       rx_stb_i,
	input  wire logic       rx_dv_i,
	input  wire logic [3:0] rxd_i,
	input  wire logic       rx_er_i,
	output logic            rx_stb_o,
	output logic            rx_dv_o,
	output logic [3:0]      rxd_o,
	output logic            rx_er_o
);

	typedef struct packed {
		logic [1:0] cnt;
		logic       sfd;
		logic       stb;
		logic       dv;
		logic [3:0] d;
		logic       er;
	} phymc_pre_s;

	phymc_pre_s r_r;
	phymc_pre_s r_nxt;
	logic       drop;

	// 100: one byte dropped for fixed latency; 10: everything before sfd
	// drop or pass
	assign drop = rx_dv_i && (speed100_i
		? (!restore100_i && r_r.cnt != PHYMC_DROP100)
		: (!restore10_i && !r_r.sfd && rxd_i != PHYMC_NIB_SFD));

	always_comb
	begin
		r_nxt     = r_r;
		r_nxt.stb = rx_stb_i;
		if (rx_stb_i)
		begin
			if (!rx_dv_i)
			begin
				r_nxt.cnt = '0;
				r_nxt.sfd = 1'b0;
			end
			else
			begin
				if (r_r.cnt != PHYMC_DROP100)
					r_nxt.cnt = r_r.cnt + 2'h1;
				if (rxd_i == PHYMC_NIB_SFD)
					r_nxt.sfd = 1'b1;
			end
			r_nxt.dv = rx_dv_i && !drop;
			r_nxt.d  = drop ? 4'h0 : rxd_i;
			r_nxt.er = rx_er_i && !drop;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			r_r <= '0;
		else
			r_r <= r_nxt;
	end

	assign rx_stb_o = r_r.stb;
	assign rx_dv_o  = r_r.dv;
	assign rxd_o    = r_r.d;
	assign rx_er_o  = r_r.er;

endmodule // phymc_preamble

// ===== phymc_regs.sv
// management register slice: next page word, preamble control, counter, interrupts
`timescale 1ns/100ps
// Function
// - The 100 Mb preamble bit passes the preamble when 1, drops one byte when 0, and resets to 1 only for strap 100.
// - The 10 Mb preamble bit passes the preamble when 1, strips it up to the delimiter when 0, and resets to 0.
// - A 16-bit read-only count of frames with symbol errors resets to zero and clears when read.
// - A read-write jabber interrupt enable, reset 0, gates jabber events.
// - A read-write receive error interrupt enable, reset 0, gates receive error events.
// - A read-write page received interrupt enable, reset 0, gates new page events.
// - A read-write parallel detect fault interrupt enable, reset 0, gates those faults.
// - A read-write partner acknowledge interrupt enable, reset 0, gates those events.
// - A read-write link down interrupt enable, reset 0, gates loss of link.
// - A read-write remote fault interrupt enable, reset 0, gates remote faults.
// - A read-only bit, reset 0, shows whether the partner can act on its next page.
// - A read-only bit, reset 0, shows the partner toggle bit, inverse of the last sent toggle.
// - A read-write link up interrupt enable, reset 0, gates link up events.
// - A low status byte holds one sticky bit per source, set by its event and cleared by a read.
module phymc_regs
	import phymc_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        mdc_i,
	input  wire logic        mdio_i,
	output logic             mdio_o,
	output logic             mdio_oe_o,
	input  wire logic [4:0]  phy_addr_i,
	input  wire logic [2:0]  config_i,
	input  wire logic        lp_np_load_i,
	input  wire logic [15:0] lp_np_word_i,
	input  wire logic        evt_jabber_i,
	input  wire logic        evt_page_rx_i,
	input  wire logic        evt_pd_fault_i,
	input  wire logic        evt_lp_ack_i,
	input  wire logic        evt_link_down_i,
	input  wire logic        evt_remote_fault_i,
	input  wire logic        evt_link_up_i,
	input  wire logic        speed100_i,
	input  wire logic        rx_stb_i,
	input  wire logic        rx_dv_i,
	input  wire logic [3:0]  rxd_i,
	input  wire logic        rx_er_i,
	output logic             rx_stb_o,
	output logic             rx_dv_o,
	output logic [3:0]       rxd_o,
	output logic             rx_er_o,
	output logic             irq_o
);

	typedef struct packed {
		logic [2:0]               cfg_s1;
		logic [2:0]               cfg_s2;
		logic [1:0]               strap_cnt;
		logic                     strap_done;
		logic                     pre100;
		logic                     pre10;
		logic [15:0]              lpnp;
		logic [15:0]              sercnt;
		logic                     ferr;
		logic [PHYMC_NUM_SRC-1:0] ena;
		logic [PHYMC_NUM_SRC-1:0] sts;
		logic                     irq;
	} phymc_regs_s;

	phymc_regs_s              r_r;
	phymc_regs_s              r_nxt;
	logic                     md_rd_stb;
	logic                     md_wr_stb;
	logic [4:0]               md_addr;
	logic [15:0]              md_wdat;
	logic [15:0]              rd_data;
	logic                     err_frame;
	logic [PHYMC_NUM_SRC-1:0] evt;
	logic [15:0]              cnt_base;
	logic                     cnt_clr;
	logic                     sts_clr;

	phymc_mdio u_mdio (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.mdc_i      (mdc_i),
		.mdio_i     (mdio_i),
		.phy_addr_i (phy_addr_i),
		.rd_data_i  (rd_data),
		.mdio_o     (mdio_o),
		.mdio_oe_o  (mdio_oe_o),
		.rd_stb_o   (md_rd_stb),
		.wr_stb_o   (md_wr_stb),
		.reg_addr_o (md_addr),
		.wr_data_o  (md_wdat)
	);

	phymc_preamble u_pre (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.speed100_i   (speed100_i),
		.restore100_i (r_r.pre100),
		.restore10_i  (r_r.pre10),
		.rx_stb_i     (rx_stb_i),
		.rx_dv_i      (rx_dv_i),
		.rxd_i        (rxd_i),
		.rx_er_i      (rx_er_i),
		.rx_stb_o     (rx_stb_o),
		.rx_dv_o      (rx_dv_o),
		.rxd_o        (rxd_o),
		.rx_er_o      (rx_er_o)
	);

	// a frame counts once, at its end, if any nibble carried an error
	assign err_frame = rx_stb_i && !rx_dv_i && r_r.ferr;

	// source order matches the status byte, bit 7 down to bit 0
	assign evt = {evt_jabber_i, err_frame, evt_page_rx_i, evt_pd_fault_i,
		evt_lp_ack_i, evt_link_down_i, evt_remote_fault_i, evt_link_up_i};

	assign cnt_clr  = md_rd_stb && md_addr == PHYMC_REG_SERCNT;
	assign sts_clr  = md_rd_stb && md_addr == PHYMC_REG_INTCS;
	assign cnt_base = cnt_clr ? '0 : r_r.sercnt;

	// read data; unmapped numbers read zero, reserved bits read their fixed values
	always_comb
	begin
		rd_data = '0;
		if (md_addr == PHYMC_REG_LPNP)
		begin
			rd_data = r_r.lpnp;
		end
		else if (md_addr == PHYMC_REG_MIICTL)
		begin
			rd_data = {PHYMC_MIICTL_HI, r_r.pre100, r_r.pre10, PHYMC_MIICTL_LO};
		end
		else if (md_addr == PHYMC_REG_SERCNT)
		begin
			rd_data = r_r.sercnt;
		end
		else if (md_addr == PHYMC_REG_INTCS)
		begin
			rd_data = {r_r.ena, r_r.sts};
		end
	end

	always_comb
	begin
		r_nxt        = r_r;
		r_nxt.cfg_s1 = config_i;
		r_nxt.cfg_s2 = r_r.cfg_s1;

		if (!r_r.strap_done)
		begin
			r_nxt.strap_cnt = r_r.strap_cnt + 2'h1;
			if (r_r.strap_cnt == PHYMC_STRAP_WAIT)
			begin
				r_nxt.strap_done = 1'b1;
				r_nxt.pre100     = (r_r.cfg_s2 == PHYMC_STRAP_P100);
			end
		end

		if (lp_np_load_i)
			r_nxt.lpnp = lp_np_word_i;

		if (rx_stb_i)
		begin
			if (!rx_dv_i)
				r_nxt.ferr = 1'b0;
			else if (rx_er_i)
				r_nxt.ferr = 1'b1;
		end

		r_nxt.sercnt = cnt_base;
		if (err_frame && cnt_base != PHYMC_CNT_MAX)
			r_nxt.sercnt = cnt_base + PHYMC_CNT_ONE;

		r_nxt.sts = (sts_clr ? '0 : r_r.sts) | evt;

		if (md_wr_stb)
		begin
			if (md_addr == PHYMC_REG_MIICTL)
			begin
				r_nxt.pre100 = md_wdat[PHYMC_BIT_PRE100];
				r_nxt.pre10  = md_wdat[PHYMC_BIT_PRE10];
			end
			else if (md_addr == PHYMC_REG_INTCS)
			begin
				r_nxt.ena = md_wdat[PHYMC_ENA_MSB:PHYMC_ENA_LSB];
			end
		end

		r_nxt.irq = |(r_nxt.sts & r_nxt.ena);
	end

	// strap wait also covers the two sync stages
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			r_r <= '0;
		else
			r_r <= r_nxt;
	end

	assign irq_o = r_r.irq;

endmodule // phymc_regs

// ===== phymc_regs_chk.sv
// bound port checker for the management register slice
`timescale 1ns/100ps
module phymc_regs_chk
	import phymc_pkg::*;
(
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       mdc_i,
	input wire logic       mdio_oe_o,
	input wire logic       evt_jabber_i,
	input wire logic       evt_page_rx_i,
	input wire logic       evt_pd_fault_i,
	input wire logic       evt_lp_ack_i,
	input wire logic       evt_link_down_i,
	input wire logic       evt_remote_fault_i,
	input wire logic       evt_link_up_i,
	input wire logic       speed100_i,
	input wire logic       rx_stb_i,
	input wire logic       rx_dv_i,
	input wire logic [3:0] rxd_i,
	input wire logic       rx_stb_o,
	input wire logic       rx_dv_o,
	input wire logic [3:0] rxd_o,
	input wire logic       irq_o
);
	logic       mdc_r;
	logic [3:0] quiet_r;
	logic       busy;
	logic       evt_any;
	// register side effects trail an mdc edge by a few clocks
	assign busy = quiet_r < 4'hA;
	assign evt_any = evt_jabber_i | evt_page_rx_i | evt_pd_fault_i | evt_lp_ack_i
		| evt_link_down_i | evt_remote_fault_i | evt_link_up_i;
	always_ff @(posedge clk_i)
	begin
		mdc_r <= mdc_i;
		if (rst_i || mdc_i != mdc_r)
			quiet_r <= 4'h0;
		else if (quiet_r != 4'hF)
			quiet_r <= quiet_r + 4'h1;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_rx_stb_follow:
	assert property (rx_stb_i |=> rx_stb_o)
		else $error("rx strobe not passed");
	chk_rx_out_hold:
	assert property (!rx_stb_i |=> !rx_stb_o && $stable(rx_dv_o) && $stable(rxd_o))
		else $error("rx outputs moved without strobe");
	chk_rx_no_dv:
	assert property (rx_stb_i && !rx_dv_i |=> !rx_dv_o)
		else $error("rx valid without input valid");
	chk_rx_data_pass:
	assert property (rx_stb_i && rx_dv_i |=> !rx_dv_o || rxd_o == $past(rxd_i))
		else $error("rx nibble altered");
	chk_sfd_passes:
	assert property (rx_stb_i && rx_dv_i && !speed100_i && rxd_i == PHYMC_NIB_SFD |=> rx_dv_o)
		else $error("delimiter nibble dropped");
	chk_irq_cause:
	assert property ($rose(irq_o) |-> busy || $past(evt_any) || $past(rx_stb_i)
		|| $past(rx_stb_i, 2))
		else $error("irq rose without cause");
	chk_irq_drop:
	assert property ($fell(irq_o) |-> busy)
		else $error("irq fell without access");
	chk_irq_sticky:
	assert property (irq_o && !busy |=> irq_o)
		else $error("status cleared without read");
	chk_oe_cause:
	assert property ($rose(mdio_oe_o) |-> busy)
		else $error("mdio driven outside frame");
	chk_reset_quiet:
	assert property (disable iff (1'b0) rst_i |=> !irq_o && !mdio_oe_o && !rx_stb_o)
		else $error("outputs active in reset");
endmodule // phymc_regs_chk
bind phymc_regs phymc_regs_chk i_phymc_regs_chk (.clk_i, .rst_i, .mdc_i, .mdio_oe_o,
	.evt_jabber_i, .evt_page_rx_i, .evt_pd_fault_i, .evt_lp_ack_i, .evt_link_down_i,
	.evt_remote_fault_i, .evt_link_up_i, .speed100_i, .rx_stb_i, .rx_dv_i, .rxd_i,
	.rx_stb_o, .rx_dv_o, .rxd_o, .irq_o);

// ===== phymc_sta.sv
// station management master model driving mdc and mdio
`timescale 1ns/100ps
module phymc_sta
	import phymc_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic mdio_i,
	output logic      mdc_o,
	output logic      mdio_o,
	output logic      mdio_oe_o
);
	initial
	begin
		mdc_o = 1'b0;
		mdio_o = 1'b0;
		mdio_oe_o = 1'b0;
	end
	// six clocks per half period, sampled just before the rise
	task automatic bit_xfer(input logic v, input logic oe, output logic s);
		@(posedge clk_i);
		mdc_o <= 1'b0;
		mdio_o <= v;
		mdio_oe_o <= oe;
		repeat (5) @(posedge clk_i);
		@(negedge clk_i);
		s = mdio_i;
		@(posedge clk_i);
		mdc_o <= 1'b1;
		repeat (5) @(posedge clk_i);
	endtask
	task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [13:0] hdr;
		logic        s;
		logic        wo;
		hdr = {2'b01, op, pa, ra};
		wo = (op == PHYMC_MD_OP_WR);
		repeat (32) bit_xfer(1'b1, 1'b1, s);
		for (int i = 13; i >= 0; i--)
			bit_xfer(hdr[i], 1'b1, s);
		bit_xfer(1'b1, wo, s);
		bit_xfer(1'b0, wo, s);
		for (int i = 15; i >= 0; i--)
		begin
			bit_xfer(wd[i], wo, s);
			rd[i] = s;
		end
		// one released period lets the device drop its drive
		bit_xfer(1'b1, 1'b0, s);
		@(posedge clk_i);
		mdc_o <= 1'b0;
	endtask
endmodule // phymc_sta

// ===== phymc_regs_tb.sv
// self-checking bench for the management register slice
`timescale 1ns/100ps
module phymc_regs_tb
	import phymc_pkg::*;
;
	localparam logic [4:0] PA = 5'h03;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        lp_np_load_i = 1'b0;
	logic [15:0] lp_np_word_i = 16'h0000;
	logic [7:0]  evt = 8'h00;
	logic        speed100_i = 1'b1;
	logic        rx_stb_i = 1'b0;
	logic        rx_dv_i = 1'b0;
	logic [3:0]  rxd_i = 4'h0;
	logic        rx_er_i = 1'b0;
	logic [2:0]  config_i = 3'h4;
	logic        mdc_i, m_o, m_oe, mdio_o, mdio_oe_o, rx_stb_o, rx_dv_o, rx_er_o, irq_o;
	logic [3:0]  rxd_o;
	wire logic   mdio_i;
	int          n_tests = 0;
	int          n_fail = 0;
	always #2 clk_i = ~clk_i;
	// pulled-up line when nobody drives
	assign mdio_i = mdio_oe_o ? mdio_o : (m_oe ? m_o : 1'b1);
	phymc_regs i_phymc_regs (.clk_i, .rst_i, .mdc_i, .mdio_i, .mdio_o, .mdio_oe_o,
		.phy_addr_i(PA), .config_i, .lp_np_load_i, .lp_np_word_i,
		.evt_jabber_i(evt[7]), .evt_page_rx_i(evt[5]), .evt_pd_fault_i(evt[4]),
		.evt_lp_ack_i(evt[3]), .evt_link_down_i(evt[2]), .evt_remote_fault_i(evt[1]),
		.evt_link_up_i(evt[0]), .speed100_i, .rx_stb_i, .rx_dv_i, .rxd_i, .rx_er_i,
		.rx_stb_o, .rx_dv_o, .rxd_o, .rx_er_o, .irq_o);
	phymc_sta i_phymc_sta (.clk_i, .mdio_i, .mdc_o(mdc_i), .mdio_o(m_o), .mdio_oe_o(m_oe));
	task automatic test_done;
		$display("tests %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [4:0] ra, input logic [15:0] d);
		logic [15:0] v;
		i_phymc_sta.frame(PHYMC_MD_OP_WR, PA, ra, d, v);
	endtask
	task automatic rd(input logic [4:0] ra, input logic [15:0] e);
		logic [15:0] v;
		i_phymc_sta.frame(PHYMC_MD_OP_RD, PA, ra, 16'h0000, v);
		cmp($sformatf("reg %h", ra), e, v);
	endtask
	task automatic nib(input logic [3:0] d, input logic v, input logic e, input logic xdv);
		@(posedge clk_i);
		rx_stb_i <= 1'b1;
		rx_dv_i <= v;
		rxd_i <= d;
		rx_er_i <= e;
		@(posedge clk_i);
		rx_stb_i <= 1'b0;
		#1;
		cmp("rx strobe", 16'h0001, {15'h0000, rx_stb_o});
		cmp("rx valid", {15'h0000, xdv}, {15'h0000, rx_dv_o});
		cmp("rx error", {15'h0000, e && xdv}, {15'h0000, rx_er_o});
		if (xdv)
			cmp("rx nibble", {12'h000, d}, {12'h000, rxd_o});
	endtask
	// fifteen preamble nibbles, delimiter, one data nibble, idle
	task automatic rx_frame(input int nsup, input logic e);
		for (int i = 0; i < 16; i++)
			nib(i < 15 ? 4'h5 : PHYMC_NIB_SFD, 1'b1, 1'b0, i >= nsup);
		nib(4'hA, 1'b1, e, 1'b1);
		nib(4'h0, 1'b0, 1'b0, 1'b0);
		repeat (2) @(posedge clk_i);
		#1;
	endtask
	task automatic t_reset;
		rd(PHYMC_REG_MIICTL, 16'h0081);
		rd(PHYMC_REG_SERCNT, 16'h0000);
		rd(PHYMC_REG_INTCS, 16'h0000);
		rd(PHYMC_REG_LPNP, 16'h0000);
		rd(5'h1F, 16'h0000);
		$display("t_reset done");
	endtask
	task automatic t_regs;
		wr(PHYMC_REG_MIICTL, 16'hFFFF);
		rd(PHYMC_REG_MIICTL, 16'h00C1);
		wr(PHYMC_REG_MIICTL, 16'h0000);
		rd(PHYMC_REG_MIICTL, 16'h0001);
		wr(PHYMC_REG_INTCS, 16'hFFFF);
		rd(PHYMC_REG_INTCS, 16'hFF00);
		wr(PHYMC_REG_LPNP, 16'hFFFF);
		wr(PHYMC_REG_SERCNT, 16'hFFFF);
		rd(PHYMC_REG_LPNP, 16'h0000);
		rd(PHYMC_REG_SERCNT, 16'h0000);
		$display("t_regs done");
	endtask
	task automatic t_np;
		for (int i = 0; i < 2; i++)
		begin
			@(posedge clk_i);
			lp_np_word_i <= i ? 16'h0800 : 16'h1000;
			lp_np_load_i <= 1'b1;
			@(posedge clk_i);
			lp_np_load_i <= 1'b0;
			rd(PHYMC_REG_LPNP, i ? 16'h0800 : 16'h1000);
		end
		$display("t_np done");
	endtask
	// status set while masked must raise irq once enabled
	task automatic t_irq;
		logic [15:0] m;
		for (int k = 0; k < 8; k++)
			if (k != 6)
			begin
				m = 16'h0001 << k;
				wr(PHYMC_REG_INTCS, ~(m << 8) & 16'hFF00);
				@(posedge clk_i);
				evt[k] <= 1'b1;
				@(posedge clk_i);
				evt[k] <= 1'b0;
				repeat (2) @(posedge clk_i);
				#1;
				cmp("irq masked", 16'h0000, {15'h0000, irq_o});
				wr(PHYMC_REG_INTCS, m << 8);
				#1;
				cmp("irq enabled", 16'h0001, {15'h0000, irq_o});
				rd(PHYMC_REG_INTCS, (m << 8) | m);
				cmp("irq cleared", 16'h0000, {15'h0000, irq_o});
				rd(PHYMC_REG_INTCS, m << 8);
			end
		$display("t_irq done");
	endtask
	task automatic t_rx;
		wr(PHYMC_REG_INTCS, 16'h4000);
		wr(PHYMC_REG_MIICTL, 16'h0000);
		rx_frame(2, 1'b1);
		cmp("irq rx error", 16'h0001, {15'h0000, irq_o});
		wr(PHYMC_REG_MIICTL, 16'h0080);
		rx_frame(0, 1'b1);
		@(posedge clk_i);
		speed100_i <= 1'b0;
		wr(PHYMC_REG_MIICTL, 16'h0000);
		rx_frame(15, 1'b1);
		wr(PHYMC_REG_MIICTL, 16'h0040);
		rx_frame(0, 1'b0);
		rd(PHYMC_REG_SERCNT, 16'h0003);
		rd(PHYMC_REG_SERCNT, 16'h0000);
		rd(PHYMC_REG_INTCS, 16'h4040);
		cmp("irq after read", 16'h0000, {15'h0000, irq_o});
		$display("t_rx done");
	endtask
	// mid-run reset with another strap must bring the irq, miictl, intcs and lpnp defaults back
	task automatic t_strap;
		@(posedge clk_i);
		rst_i <= 1'b1;
		config_i <= 3'h0;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (10) @(posedge clk_i);
		#1;
		cmp("irq after reset", 16'h0000, {15'h0000, irq_o});
		rd(PHYMC_REG_MIICTL, 16'h0001);
		rd(PHYMC_REG_INTCS, 16'h0000);
		rd(PHYMC_REG_LPNP, 16'h0000);
		$display("t_strap done");
	endtask
	initial
	begin
		repeat (90000) @(posedge clk_i);
		n_fail++;
		test_done();
	end
	initial
	begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (10) @(posedge clk_i);
		t_reset();
		t_regs();
		t_np();
		t_irq();
		t_rx();
		t_strap();
		test_done();
	end
endmodule // phymc_regs_tb
